//--- inc/aid_pkg.sv
// Purpose: Shared constants and types for the analog input diagnostic record.
// Assumes: 25 MHz system clock; record of twenty bytes, timestamp little-endian.
// Notes:   Offsets are byte positions inside the full record.
package aid_pkg;

    // ========================================================================
    // Timing
    // ========================================================================
    localparam int unsigned CLK_HZ        = 25_000_000;
    localparam int unsigned TICK_US       = 1;
    localparam int unsigned CYC_PER_TICK  = (CLK_HZ / 1_000_000) * TICK_US;
    localparam int unsigned TICK_CNT_W    = 5;

    // ========================================================================
    // Record geometry
    // ========================================================================
    localparam int unsigned REC_BYTES     = 20;
    localparam int unsigned HDR_BYTES     = 4;
    localparam int unsigned ADDR_W        = 5;
    localparam int unsigned SPARE_CH      = 6;

    localparam logic [4:0] OFS_MOD_ERR    = 5'h00;
    localparam logic [4:0] OFS_MOD_INFO   = 5'h01;
    localparam logic [4:0] OFS_SPARE_ERR  = 5'h02;
    localparam logic [4:0] OFS_INT_ERR    = 5'h03;
    localparam logic [4:0] OFS_CH_KIND    = 5'h04;
    localparam logic [4:0] OFS_DIAG_BITS  = 5'h05;
    localparam logic [4:0] OFS_CH_COUNT   = 5'h06;
    localparam logic [4:0] OFS_GRP_ERR    = 5'h07;
    localparam logic [4:0] OFS_CH0_ERR    = 5'h08;
    localparam logic [4:0] OFS_CH1_ERR    = 5'h09;
    localparam logic [4:0] OFS_SPARE_CH   = 5'h0a;
    localparam logic [4:0] OFS_STAMP      = 5'h10;

    // ========================================================================
    // Access selectors
    // ========================================================================
    localparam logic [7:0]  SET_HEADER    = 8'h00;
    localparam logic [7:0]  SET_FULL      = 8'h01;
    localparam logic [15:0] CAN_HEADER    = 16'h2f00;
    localparam logic [15:0] CAN_FULL      = 16'h2f01;
    localparam logic [15:0] ETH_INDEX     = 16'h5005;
    localparam logic [7:0]  SUB_FIRST     = 8'h02;
    localparam logic [7:0]  SUB_LAST_BYTE = 8'h11;
    localparam logic [7:0]  SUB_STAMP     = 8'h13;

    // ========================================================================
    // Values after reset and fixed codes
    // ========================================================================
    localparam logic [7:0] MOD_ERR_RST    = 8'h00;
    localparam logic [7:0] MOD_INFO_RST   = 8'h15;
    localparam logic [7:0] ZERO_BYTE      = 8'h00;
    localparam logic [7:0] CH_KIND_RST    = 8'h71;
    localparam logic [7:0] DIAG_BITS_RST  = 8'h08;
    localparam logic [7:0] CH_COUNT_RST   = 8'h02;
    localparam logic [7:0] CH_ERR_RST     = 8'h00;
    localparam logic [31:0] STAMP_RST     = 32'h0000_0000;
    localparam logic [3:0] CLASS_ANALOG   = 4'h5;

    localparam logic [6:0] KIND_DIG_IN    = 7'h70;
    localparam logic [6:0] KIND_ANA_IN    = 7'h71;
    localparam logic [6:0] KIND_DIG_OUT   = 7'h72;
    localparam logic [6:0] KIND_ANA_OUT   = 7'h73;
    localparam logic [6:0] KIND_ANA_IO    = 7'h74;
    localparam logic [6:0] KIND_COUNTER   = 7'h76;

    // ========================================================================
    // Field positions
    // ========================================================================
    localparam int unsigned ME_FAIL       = 0;
    localparam int unsigned ME_INT        = 1;
    localparam int unsigned ME_EXT        = 2;
    localparam int unsigned ME_CHAN       = 3;
    localparam int unsigned ME_AUX        = 4;
    localparam int unsigned ME_PARAM      = 7;
    localparam int unsigned MI_CHAN_INFO  = 4;
    localparam int unsigned IE_BUF_OVF    = 3;
    localparam int unsigned IE_COMM       = 4;
    localparam int unsigned IE_IRQ_LOST   = 6;
    localparam int unsigned CE_CFG        = 0;
    localparam int unsigned CE_IRQ_LOST   = 5;
    localparam int unsigned CE_UNDER      = 6;
    localparam int unsigned CE_OVER       = 7;

    // ========================================================================
    // Types
    // ========================================================================
    typedef enum logic [1:0] {
        AID_ACC_SET,
        AID_ACC_CAN,
        AID_ACC_ETH,
        AID_ACC_NONE
    } aid_acc_t;

endpackage : aid_pkg

//--- inc/aid_rec_if.sv
// Purpose: Carrier between the record logic and its read store.
// Assumes: One read per cycle at most.
// Notes:   Record is flat, byte 0 in the low bits.
interface aid_rec_if;
    logic [aid_pkg::REC_BYTES*8-1:0] record;
    logic                            rd_en;
    logic [aid_pkg::ADDR_W-1:0]      rd_addr;
    logic [7:0]                      rd_data;

    modport store (input record, input rd_en, input rd_addr, output rd_data);
    modport user  (output record, output rd_en, output rd_addr, input rd_data);
endinterface : aid_rec_if

//--- design/aid_rec_mem.sv
// Purpose: Byte read store of the diagnostic record with registered data.
// Assumes: Address already checked against the record length.
// Notes:   Data holds its last value between reads.
module aid_rec_mem (
    // Clock and reset
    input  wire logic  sys_clk_i,
    input  wire logic  rst_b_i,
    // Record port
    aid_rec_if.store   rec
);
    import aid_pkg::*;

    function automatic logic [7:0] byte_of(input logic [REC_BYTES*8-1:0] r,
                                           input logic [ADDR_W-1:0] a);
        byte_of = ZERO_BYTE;
        for (int i = 0; i < REC_BYTES; i++) begin
            if (a == ADDR_W'(i)) begin
                byte_of = r[i*8 +: 8];
            end
        end
    endfunction

    // ========================================================================
    // Read register
    // ========================================================================
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rec.rd_data <= ZERO_BYTE;
        end else if (rec.rd_en) begin
            rec.rd_data <= byte_of(rec.record, rec.rd_addr);
        end
    end

endmodule // aid_rec_mem

//--- design/aid_diag_record.sv
// Purpose: Diagnostic record of a two-channel analog input module.
// Assumes: Condition inputs are levels synchronous to sys_clk_i.
// Notes:   Reads answer two cycles after the request.
module aid_diag_record #(
    parameter int unsigned NUM_CH = 2
) (
    // Clock and reset
    input  wire logic                    sys_clk_i,
    input  wire logic                    rst_b_i,
    // Read request
    input  wire logic                    rd_req_i,
    input  wire aid_pkg::aid_acc_t       rd_kind_i,
    input  wire logic [7:0]              record_set_number_i,
    input  wire logic [15:0]             object_index_i,
    input  wire logic [7:0]              object_subindex_i,
    input  wire logic [4:0]              rd_byte_i,
    // Read answer
    output logic                         rd_ack_o,
    output logic                         rd_err_o,
    output logic [7:0]                   rd_data_o,
    // Module conditions
    input  wire logic                    module_failure_i,
    input  wire logic                    external_error_i,
    input  wire logic                    aux_supply_missing_i,
    input  wire logic                    param_error_i,
    input  wire logic                    diag_buf_overflow_i,
    input  wire logic                    int_comm_error_i,
    input  wire logic                    proc_irq_lost_i,
    // Channel conditions
    input  wire logic [NUM_CH-1:0]       ch_cfg_error_i,
    input  wire logic [NUM_CH-1:0]       ch_underflow_i,
    input  wire logic [NUM_CH-1:0]       ch_overflow_i,
    input  wire logic [NUM_CH-1:0]       ch_irq_lost_i,
    // Status
    output logic                         diag_active_o,
    output logic                         diag_event_o
);
    import aid_pkg::*;

    // ========================================================================
    // Declarations
    // ========================================================================
    logic [TICK_CNT_W-1:0]  tick_cnt_r;
    logic                   tick_en;
    logic [31:0]            us_ticker_r;
    logic [7:0]             module_error_flags_r;
    logic [7:0]             internal_error_flags_r;
    logic [7:0]             channel_group_errors_r;
    logic [7:0]             chan_err_r [NUM_CH];
    logic [31:0]            diag_event_timestamp_r;
    logic [7:0]             internal_error_flags_nxt;
    logic [7:0]             chan_err_nxt [NUM_CH];
    logic [7:0]             module_error_flags_nxt;
    logic [7:0]             channel_group_errors_nxt;
    logic                   any_chan_err;
    logic                   new_error;
    logic                   dec_ok;
    logic [ADDR_W-1:0]      dec_addr;
    logic                   stage_vld_r;
    logic                   stage_err_r;

    aid_rec_if rec_bus ();

    // ========================================================================
    // Functions
    // ========================================================================
    // Bytes of one channel; bits 4 to 1 stay zero.
    function automatic logic [7:0] chan_byte(input logic cfg, input logic irq,
                                             input logic under, input logic over);
        chan_byte = CH_ERR_RST;
        chan_byte[CE_CFG]      = cfg;
        chan_byte[CE_IRQ_LOST] = irq;
        chan_byte[CE_UNDER]    = under;
        chan_byte[CE_OVER]     = over;
    endfunction

    // Selected set length: header or full record.
    function automatic logic set_fits(input logic full, input logic [4:0] b);
        if (full) begin
            set_fits = (b < 5'(REC_BYTES));
        end else begin
            set_fits = (b < 5'(HDR_BYTES));
        end
    endfunction

    // ========================================================================
    // Microsecond ticker
    // ========================================================================
    assign tick_en = (tick_cnt_r == TICK_CNT_W'(CYC_PER_TICK - 1));

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tick_cnt_r <= '0;
        end else if (tick_en) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_r + TICK_CNT_W'(1);
        end
    end

    // Natural 32-bit rollover gives the wrap after the last microsecond.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            us_ticker_r <= STAMP_RST;
        end else if (tick_en) begin
            us_ticker_r <= us_ticker_r + 32'h0000_0001;
        end
    end

    // ========================================================================
    // Error byte assembly
    // ========================================================================
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            chan_err_nxt[c] = chan_byte(ch_cfg_error_i[c], ch_irq_lost_i[c],
                                        ch_underflow_i[c], ch_overflow_i[c]);
        end
    end

    always_comb begin
        any_chan_err             = 1'b0;
        channel_group_errors_nxt = ZERO_BYTE;
        for (int c = 0; c < NUM_CH; c++) begin
            any_chan_err                = any_chan_err | (|chan_err_nxt[c]);
            channel_group_errors_nxt[c] = |chan_err_nxt[c];
        end
    end

    always_comb begin
        internal_error_flags_nxt              = ZERO_BYTE;
        internal_error_flags_nxt[IE_BUF_OVF]  = diag_buf_overflow_i;
        internal_error_flags_nxt[IE_COMM]     = int_comm_error_i;
        internal_error_flags_nxt[IE_IRQ_LOST] = proc_irq_lost_i;
    end

    // The internal error summary follows the internal byte so both agree.
    always_comb begin
        module_error_flags_nxt           = MOD_ERR_RST;
        module_error_flags_nxt[ME_FAIL]  = module_failure_i;
        module_error_flags_nxt[ME_INT]   = |internal_error_flags_nxt;
        module_error_flags_nxt[ME_EXT]   = external_error_i;
        module_error_flags_nxt[ME_CHAN]  = any_chan_err;
        module_error_flags_nxt[ME_AUX]   = aux_supply_missing_i;
        module_error_flags_nxt[ME_PARAM] = param_error_i;
    end

    // ========================================================================
    // Record registers
    // ========================================================================
    // Bytes track the conditions, so they fall back to defaults on their own.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            module_error_flags_r   <= MOD_ERR_RST;
            internal_error_flags_r <= ZERO_BYTE;
            channel_group_errors_r <= ZERO_BYTE;
        end else begin
            module_error_flags_r   <= module_error_flags_nxt;
            internal_error_flags_r <= internal_error_flags_nxt;
            channel_group_errors_r <= channel_group_errors_nxt;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int c = 0; c < NUM_CH; c++) begin
                chan_err_r[c] <= CH_ERR_RST;
            end
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                chan_err_r[c] <= chan_err_nxt[c];
            end
        end
    end

    // ========================================================================
    // Event timestamp
    // ========================================================================
    // Any bit of the module, internal or group error byte that rises counts as a new diagnostic event.
    assign new_error = |(module_error_flags_nxt & ~module_error_flags_r)
                     | |(internal_error_flags_nxt & ~internal_error_flags_r)
                     | |(channel_group_errors_nxt & ~channel_group_errors_r);

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            diag_event_timestamp_r <= STAMP_RST;
        end else if (new_error) begin
            diag_event_timestamp_r <= us_ticker_r;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            diag_event_o  <= 1'b0;
            diag_active_o <= 1'b0;
        end else begin
            diag_event_o  <= new_error;
            diag_active_o <= |module_error_flags_nxt;
        end
    end

    // ========================================================================
    // Record image
    // ========================================================================
    always_comb begin
        rec_bus.record = '0;
        rec_bus.record[OFS_MOD_ERR*8 +: 8]   = module_error_flags_r;
        rec_bus.record[OFS_MOD_INFO*8 +: 8]  = {3'h0, 1'b1, CLASS_ANALOG};
        rec_bus.record[OFS_SPARE_ERR*8 +: 8] = ZERO_BYTE;
        rec_bus.record[OFS_INT_ERR*8 +: 8]   = internal_error_flags_r;
        rec_bus.record[OFS_CH_KIND*8 +: 8]   = {1'b0, KIND_ANA_IN};
        rec_bus.record[OFS_DIAG_BITS*8 +: 8] = DIAG_BITS_RST;
        rec_bus.record[OFS_CH_COUNT*8 +: 8]  = CH_COUNT_RST;
        rec_bus.record[OFS_GRP_ERR*8 +: 8]   = channel_group_errors_r;
        rec_bus.record[OFS_CH0_ERR*8 +: 8]   = chan_err_r[0];
        rec_bus.record[OFS_CH1_ERR*8 +: 8]   = chan_err_r[1];
        rec_bus.record[OFS_STAMP*8 +: 32]    = diag_event_timestamp_r;
    end

    // ========================================================================
    // Request decode
    // ========================================================================
    // Subindex 13h spans four timestamp bytes picked by rd_byte_i; subindexes 02h to 11h
    // each name one byte and want rd_byte_i at zero.
    always_comb begin
        dec_ok   = 1'b0;
        dec_addr = '0;
        unique case (rd_kind_i)
            AID_ACC_SET: begin
                if (record_set_number_i == SET_FULL) begin
                    dec_ok = set_fits(1'b1, rd_byte_i);
                end else if (record_set_number_i == SET_HEADER) begin
                    dec_ok = set_fits(1'b0, rd_byte_i);
                end
                dec_addr = rd_byte_i;
            end
            AID_ACC_CAN: begin
                if (object_index_i == CAN_FULL) begin
                    dec_ok = set_fits(1'b1, rd_byte_i);
                end else if (object_index_i == CAN_HEADER) begin
                    dec_ok = set_fits(1'b0, rd_byte_i);
                end
                dec_addr = rd_byte_i;
            end
            AID_ACC_ETH: begin
                if (object_index_i != ETH_INDEX) begin
                    dec_ok = 1'b0;
                end else if (object_subindex_i == SUB_STAMP) begin
                    dec_ok   = (rd_byte_i < 5'h04);
                    dec_addr = OFS_STAMP + rd_byte_i[1:0];
                end else if ((object_subindex_i >= SUB_FIRST)
                          && (object_subindex_i <= SUB_LAST_BYTE)) begin
                    dec_ok   = (rd_byte_i == 5'h00);
                    dec_addr = 5'(object_subindex_i - SUB_FIRST);
                end
            end
            AID_ACC_NONE: dec_ok = 1'b0;
        endcase
    end

    // ========================================================================
    // Read pipeline
    // ========================================================================
    // The store reads at the taking edge; this stage lines the flags up with its data.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stage_vld_r  <= 1'b0;
            stage_err_r  <= 1'b0;
        end else begin
            stage_vld_r  <= rd_req_i;
            stage_err_r  <= rd_req_i & ~dec_ok;
        end
    end

    assign rec_bus.rd_en   = rd_req_i & dec_ok;
    assign rec_bus.rd_addr = dec_addr;

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_ack_o <= 1'b0;
            rd_err_o <= 1'b0;
        end else begin
            rd_ack_o <= stage_vld_r;
            rd_err_o <= stage_err_r;
        end
    end

    // A refused read keeps the store untouched, so data is forced to zero.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_data_o <= ZERO_BYTE;
        end else if (stage_vld_r) begin
            rd_data_o <= stage_err_r ? ZERO_BYTE : rec_bus.rd_data;
        end
    end

    aid_rec_mem u_mem (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .rec       (rec_bus.store)
    );

endmodule // aid_diag_record

//--- testbench/aid_diag_record_props.sv
// Purpose: Port assertions for the diagnostic record.
// Assumes: One clock domain, reset active low.
// Notes:   Answers come two cycles after a request.
module aid_diag_record_props #(
    parameter int unsigned NUM_CH = 2
) (
    input wire logic              sys_clk_i,
    input wire logic              rst_b_i,
    input wire logic              rd_req_i,
    input wire aid_pkg::aid_acc_t rd_kind_i,
    input wire logic [7:0]        record_set_number_i,
    input wire logic [15:0]       object_index_i,
    input wire logic [7:0]        object_subindex_i,
    input wire logic [4:0]        rd_byte_i,
    input wire logic              rd_ack_o,
    input wire logic              rd_err_o,
    input wire logic [7:0]        rd_data_o,
    input wire logic              module_failure_i,
    input wire logic              external_error_i,
    input wire logic              diag_active_o,
    input wire logic              diag_event_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import aid_pkg::*;
    // =====
    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    ack_two_late_a: assert property (rd_req_i |-> ##2 rd_ack_o)
        else $error("answer not two cycles after request");
    ack_has_cause_a: assert property (rd_ack_o |-> $past(rd_req_i, 2))
        else $error("answer without a request");
    full_set_ok_a: assert property (rd_req_i && rd_kind_i == AID_ACC_SET &&
        record_set_number_i == SET_FULL && rd_byte_i < 5'h14 |-> ##2 !rd_err_o)
        else $error("full set byte refused");
    header_limit_a: assert property (rd_req_i && rd_kind_i == AID_ACC_SET &&
        record_set_number_i == SET_HEADER && rd_byte_i > 5'h03 |-> ##2 rd_err_o)
        else $error("header byte past four served");
    can_full_ok_a: assert property (rd_req_i && rd_kind_i == AID_ACC_CAN &&
        object_index_i == CAN_FULL && rd_byte_i < 5'h14 |-> ##2 !rd_err_o)
        else $error("full index byte refused");
    eth_gap_a: assert property (rd_req_i && rd_kind_i == AID_ACC_ETH &&
        object_subindex_i == 8'h12 |-> ##2 rd_ack_o && rd_err_o)
        else $error("unmapped subindex served");
    refused_zero_a: assert property (rd_ack_o && rd_err_o |-> rd_data_o == 8'h00)
        else $error("refused answer carries data");
    fail_flag_a: assert property (module_failure_i |=> diag_active_o)
        else $error("module failure not flagged");
    event_rise_a: assert property ($rose(external_error_i) |=> diag_event_o)
        else $error("error rise without event");
endmodule // aid_diag_record_props
bind aid_diag_record aid_diag_record_props #(.NUM_CH(NUM_CH)) u_props (.*);

//--- testbench/aid_head_model.sv
// Purpose: Head station issuing byte reads to the record.
// Assumes: Requests change 1 ns after the rising edge.
// Notes:   Selectors are scrambled between requests, as a real bus may be.
module aid_head_model (
    // Clock
    input  wire logic             sys_clk_i,
    // Request
    output logic                  rd_req_o,
    output aid_pkg::aid_acc_t     rd_kind_o,
    output logic [7:0]            set_o,
    output logic [15:0]           index_o,
    output logic [7:0]            sub_o,
    output logic [4:0]            byte_o,
    // Answer
    input  wire logic             rd_ack_i,
    input  wire logic             rd_err_i,
    input  wire logic [7:0]       rd_data_i
);
    timeunit 1ns;
    timeprecision 1ps;
    import aid_pkg::*;
    // =====
    // Read cycle
    initial {rd_req_o, set_o, index_o, sub_o, byte_o} = '0;
    initial rd_kind_o = AID_ACC_NONE;
    task automatic read(input aid_acc_t k, input logic [7:0] s, input logic [15:0] x,
                        input logic [7:0] u, input logic [4:0] b,
                        output logic [7:0] d, output logic e, output logic late);
        late = 1'b1;
        @(posedge sys_clk_i);
        #1;
        rd_kind_o = k;
        {rd_req_o, set_o, index_o, sub_o, byte_o} = {1'b1, s, x, u, b};
        @(posedge sys_clk_i);
        #1;
        rd_kind_o = aid_acc_t'(~k);
        {rd_req_o, set_o, index_o, sub_o, byte_o} = {1'b0, ~s, ~x, ~u, ~b};
        for (int n = 0; n < 4 && late; n++) begin
            @(posedge sys_clk_i);
            #1;
            if (rd_ack_i) begin
                late = 1'b0;
                d = rd_data_i;
                e = rd_err_i;
            end
        end
    endtask
endmodule // aid_head_model

//--- testbench/analog_input_diag_record_bench.sv
// Purpose: Self-checking bench of the diagnostic record.
// Assumes: 25 MHz clock, reads through the head model.
// Notes:   Stamp spacing is measured in whole ticker periods.
module analog_input_diag_record_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import aid_pkg::*;
    // =====
    // Signals
    logic sys_clk_i, rst_b_i, rd_req_i, rd_ack_o, rd_err_o, diag_active_o, diag_event_o;
    aid_acc_t rd_kind_i;
    logic [7:0] record_set_number_i, object_subindex_i, rd_data_o, got, e0, e3;
    logic [15:0] object_index_i;
    logic [4:0] rd_byte_i;
    logic module_failure_i, external_error_i, aux_supply_missing_i, param_error_i;
    logic diag_buf_overflow_i, int_comm_error_i, proc_irq_lost_i, err, late, evt;
    logic [1:0] ch_cfg_error_i, ch_underflow_i, ch_overflow_i, ch_irq_lost_i;
    logic [6:0] m;
    logic [31:0] t1;
    logic [7:0] dflt[20] = '{1: 8'h15, 4: 8'h71, 5: 8'h08, 6: 8'h02, default: 8'h00};
    logic [7:0] cv[4] = '{8'h10, 8'h08, 8'h40, 8'h02};
    logic [15:0] cx[4] = '{16'h4000, 16'h0080, 16'h0100, 16'h0020};
    logic [7:0] gq[4] = '{8'h01, 8'h02, 8'h01, 8'h02};
    int n_errors = 0, checks = 0, cyc = 0, ca, c_first;
    aid_diag_record #(.NUM_CH(2)) u_aid_diag_record (.*);
    aid_head_model u_aid_head_model (.sys_clk_i(sys_clk_i), .rd_req_o(rd_req_i),
        .rd_kind_o(rd_kind_i), .set_o(record_set_number_i), .index_o(object_index_i),
        .sub_o(object_subindex_i), .byte_o(rd_byte_i), .rd_ack_i(rd_ack_o),
        .rd_err_i(rd_err_o), .rd_data_i(rd_data_o));
    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) cyc <= cyc + 1;
    // =====
    // Tasks
    task automatic complete_run();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk_byte(input string nm, input logic [7:0] ex, input logic [7:0] ac);
        checks++;
        if (ac !== ex) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, ex, ac);
        end
    endtask
    task automatic chk_bit(input string nm, input logic ex, input logic ac);
        checks++;
        if (ac !== ex) begin
            n_errors++;
            $display("wrong value %s expected %b seen %b", nm, ex, ac);
        end
    endtask
    task automatic rd(input aid_acc_t k, input logic [7:0] s, input logic [15:0] x,
                      input logic [7:0] u, input int b, input logic [7:0] ed, input logic ee);
        u_aid_head_model.read(k, s, x, u, 5'(b), got, err, late);
        n_errors += int'(late);
        if (late) complete_run();
        chk_bit("refusal flag", ee, err);
        chk_byte("answer byte", ed, got);
    endtask
    task automatic cond(input logic [6:0] mv, input logic [7:0] c);
        @(posedge sys_clk_i);
        #1;
        ca = cyc;
        {module_failure_i, external_error_i, aux_supply_missing_i, param_error_i,
         diag_buf_overflow_i, int_comm_error_i, proc_irq_lost_i} = mv;
        {ch_cfg_error_i, ch_underflow_i, ch_overflow_i, ch_irq_lost_i} = c;
        @(posedge sys_clk_i);
        #1 evt = diag_event_o;
        @(posedge sys_clk_i);
        #1;
    endtask
    // =====
    // Sequence
    initial begin
        rst_b_i = 1'b0;
        cond(7'h00, 8'h00);
        repeat (3) @(posedge sys_clk_i);
        #1;
        rst_b_i = 1'b1;
        for (int b = 0; b < 20; b++) rd(AID_ACC_SET, SET_FULL, 0, 0, b, dflt[b], 0);
        for (int b = 0; b < 5; b++) rd(AID_ACC_SET, SET_HEADER, 0, 0, b, dflt[b % 20] & {8{b < 4}}, b == 4);
        rd(AID_ACC_CAN, 0, CAN_HEADER, 0, 1, 8'h15, 0);
        rd(AID_ACC_CAN, 0, CAN_HEADER, 0, 4, 8'h00, 1);
        rd(AID_ACC_CAN, 0, CAN_FULL, 0, 6, 8'h02, 0);
        rd(AID_ACC_CAN, 0, 16'h2f02, 0, 0, 8'h00, 1);
        rd(AID_ACC_NONE, SET_FULL, 0, 0, 0, 8'h00, 1);
        for (int s = 2; s < 19; s++) rd(AID_ACC_ETH, 0, ETH_INDEX, 8'(s), 0, s < 18 ? dflt[s - 2] : 0, s > 17);
        rd(AID_ACC_ETH, 0, ETH_INDEX, SUB_STAMP, 3, 8'h00, 0);
        rd(AID_ACC_ETH, 0, ETH_INDEX, 8'h14, 0, 8'h00, 1);
        for (int i = 0; i < 7; i++) begin
            m = 7'h01 << i;
            e0 = {m[3], 2'b00, m[4], 1'b0, m[5], |m[2:0], m[6]};
            e3 = {1'b0, m[0], 1'b0, m[1], m[2], 3'b000};
            cond(m, 8'h00);
            chk_bit("event pulse", 1'b1, evt);
            chk_bit("active flag", 1'b1, diag_active_o);
            rd(AID_ACC_SET, SET_FULL, 0, 0, 0, e0, 0);
            rd(AID_ACC_SET, SET_FULL, 0, 0, 3, e3, 0);
        end
        foreach (cv[i]) begin
            cond(7'h00, cv[i]);
            rd(AID_ACC_SET, SET_FULL, 0, 0, 8, cx[i][15:8], 0);
            rd(AID_ACC_SET, SET_FULL, 0, 0, 9, cx[i][7:0], 0);
            rd(AID_ACC_SET, SET_FULL, 0, 0, 7, gq[i], 0);
            rd(AID_ACC_SET, SET_FULL, 0, 0, 0, 8'h08, 0);
        end
        // The spacing of the two rises is a whole number of ticker periods.
        cond(7'h00, 8'h00);
        cond(7'h20, 8'h00);
        c_first = ca;
        for (int b = 0; b < 4; b++) begin
            u_aid_head_model.read(AID_ACC_ETH, 0, ETH_INDEX, SUB_STAMP, 5'(b), got, err, late);
            t1[8 * b +: 8] = got;
        end
        cond(7'h00, 8'h00);
        while ((cyc - c_first) % 25 != 24) begin
            @(posedge sys_clk_i);
            #1;
        end
        cond(7'h20, 8'h00);
        t1 = t1 + 32'((ca - c_first) / 25);
        for (int b = 0; b < 4; b++) rd(AID_ACC_ETH, 0, ETH_INDEX, SUB_STAMP, b, t1[8 * b +: 8], 0);
        cond(7'h00, 8'h00);
        for (int b = 0; b < 16; b++) rd(AID_ACC_SET, SET_FULL, 0, 0, b, dflt[b], 0);
        complete_run();
    end
endmodule // analog_input_diag_record_bench
